// >>> rtl/anpage_pkg.sv
/*
  Package for the auto-negotiation page and gigabit control register group:
  word offsets, field positions, reset values and the test mode type.
  Assumes a 32-bit APB slave with one 16-bit register per aligned word.
*/
// Function
// - Partner base page register is read-only, fields as received, resets to zero.
// - Parallel detection fault bit latches high until software reads it.
// - Page received bit reports a new page and latches low.
// - Partner next-page and auto-negotiation able bits reset zero; local next-page reads one.
// - Next-page transmit fields writable; message resets one, code resets to one.
// - Transmit toggle is read-only, inverse of last sent toggle, resets zero.
// - Received next page register is read-only capture, all fields reset zero.
// - Test mode field selects normal or one of four tests, resets normal.
// - Manual setup bit enables the forced role bit; role bit ignored otherwise.
// - Port type bit resets to one, meaning multi-port.
// - Gigabit ability bits reset from strap mode; low byte writable, resets zero.
package anpage_pkg;

  // ----------------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------------
  // Each register sits in its own aligned word: byte address is four times the index
  localparam int IDX_PARTNER_BASE = 5;
  localparam int IDX_EXPANSION = 6;
  localparam int IDX_NP_TRANSMIT = 7;
  localparam int IDX_NP_RECEIVE = 8;
  localparam int IDX_GIG_CONTROL = 9;
  localparam logic [11:0] OFS_PARTNER_BASE = 12'(4 * IDX_PARTNER_BASE);
  localparam logic [11:0] OFS_EXPANSION = 12'(4 * IDX_EXPANSION);
  localparam logic [11:0] OFS_NP_TRANSMIT = 12'(4 * IDX_NP_TRANSMIT);
  localparam logic [11:0] OFS_NP_RECEIVE = 12'(4 * IDX_NP_RECEIVE);
  localparam logic [11:0] OFS_GIG_CONTROL = 12'(4 * IDX_GIG_CONTROL);

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int EXP_PAR_FAULT = 4;
  localparam int EXP_PARTNER_NP = 3;
  localparam int EXP_LOCAL_NP = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_PARTNER_AN = 0;
  localparam int NPT_NEXT = 15;
  localparam int NPT_MSG = 13;
  localparam int NPT_ACK2 = 12;
  localparam int NPT_TOGGLE = 11;
  localparam int GIG_MODE_HI = 15;
  localparam int GIG_MODE_LO = 13;
  localparam int GIG_MANUAL = 12;
  localparam int GIG_ROLE = 11;
  localparam int GIG_PORT = 10;
  localparam int GIG_FDX = 9;
  localparam int GIG_HDX = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_PARTNER = 16'h0000;
  localparam logic [15:0] RST_NP_TX = 16'h2001;
  localparam logic [15:0] RST_NP_RX = 16'h0000;
  localparam logic [15:0] RST_GIG = 16'h0400;
  localparam logic [15:0] NPT_WMASK = 16'hb7ff;
  // Reserved bit 12 of the partner base page always reads zero
  localparam logic [15:0] BASE_RMASK = 16'hefff;

  typedef enum logic [2:0] {
    TM_NORMAL = 3'h0,
    TM_WAVEFORM = 3'h1,
    TM_JITTER_MASTER = 3'h2,
    TM_JITTER_SLAVE = 3'h3,
    TM_DISTORTION = 3'h4
  } test_mode_t;

endpackage

// >>> rtl/latch_bit.sv
/*
  One latching status bit with read re-arm.
  Assumes rd_clr pulses for one cycle on the edge that samples its register for a read.
*/
`timescale 1ns/1ps
module latch_bit #(
  parameter bit LATCH_HIGH = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Condition and read
  input wire logic live,
  input wire logic rd_clr,
  output logic held_q
);
  // Event wins over the re-arm: a fault arriving during the read stays caught
  logic event_now;
  logic next_d;
  assign event_now = LATCH_HIGH ? live : ~live;
  assign next_d = event_now ? LATCH_HIGH : (rd_clr ? live : held_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      held_q <= 1'b0;
    else if (clk_en)
      held_q <= next_d;
  end
endmodule

// >>> rtl/toggle_track.sv
/*
  Transmit toggle tracker: holds the inverse of the toggle sent last.
  Assumes page_sent pulses once per transmitted link code word.
*/
`timescale 1ns/1ps
module toggle_track (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Engine events
  input wire logic page_sent,
  input wire logic sent_toggle,
  output logic toggle_q
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      toggle_q <= 1'b0;
    else if (clk_en && page_sent)
      toggle_q <= ~sent_toggle;
  end
endmodule

// >>> rtl/anpage_regs.sv
/*
  APB register group for auto-negotiation pages and gigabit control.
  Assumes the negotiation engine drives its inputs synchronous to pclk and
  pulses the capture strobes for one cycle.
*/
`timescale 1ns/1ps
module anpage_regs (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap
  input wire logic [1:0] config_strap_mode,
  // Engine status
  input wire logic base_page_valid,
  input wire logic [15:0] base_page_word,
  input wire logic next_page_valid,
  input wire logic [15:0] next_page_word,
  input wire logic par_fault_live,
  input wire logic page_rx_live,
  input wire logic link_partner_np,
  input wire logic link_partner_an,
  input wire logic page_sent,
  input wire logic sent_toggle,
  // Controls to the engine
  output logic [15:0] np_tx_word,
  output logic [2:0] test_mode,
  output logic manual_role_en,
  output logic force_master,
  output logic multi_port,
  output logic adv_gig_fdx,
  output logic adv_gig_hdx
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [15:0] partner_base_q;
  logic [15:0] partner_np_q;
  logic [15:0] np_tx_q;
  logic [15:0] gig_ctrl_q;
  logic [1:0] partner_flags_q;
  logic strap_taken_q;
  logic par_fault_q;
  logic page_rx_q;
  logic toggle_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [2:0] test_mode_q;
  logic force_master_q;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire setup_cyc = psel && !penable;
  wire access_done = psel && penable && pready_q;
  wire hit_base = paddr == anpage_pkg::OFS_PARTNER_BASE;
  wire hit_exp = paddr == anpage_pkg::OFS_EXPANSION;
  wire hit_npt = paddr == anpage_pkg::OFS_NP_TRANSMIT;
  wire hit_npr = paddr == anpage_pkg::OFS_NP_RECEIVE;
  wire hit_gig = paddr == anpage_pkg::OFS_GIG_CONTROL;
  wire hit_any = hit_base || hit_exp || hit_npt || hit_npr || hit_gig;
  wire wr_npt = access_done && pwrite && hit_npt;
  wire wr_gig = access_done && pwrite && hit_gig;
  // Latches re-arm on the edge that captures the read word, so an event
  // landing on that very edge is kept for the next read instead of lost
  wire rd_exp = setup_cyc && !pwrite && hit_exp;
  wire [15:0] byte_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  wire [15:0] exp_word = {11'h000,
                          par_fault_q,
                          partner_flags_q[1],
                          1'b1,
                          page_rx_q,
                          partner_flags_q[0]};
  wire [15:0] npt_word = {np_tx_q[15:12], toggle_q, np_tx_q[10:0]};

  wire [15:0] rd_word = hit_base ? partner_base_q :
                        hit_exp ? exp_word :
                        hit_npt ? npt_word :
                        hit_npr ? partner_np_q :
                        hit_gig ? gig_ctrl_q : 16'h0000;

  wire [15:0] npt_next = (np_tx_q & ~(byte_mask & anpage_pkg::NPT_WMASK)) |
                         (pwdata[15:0] & byte_mask & anpage_pkg::NPT_WMASK);
  wire [15:0] gig_next = (gig_ctrl_q & ~byte_mask) | (pwdata[15:0] & byte_mask);
  // Strap levels land in the ability bits on the first enabled edge after reset
  wire [15:0] gig_strap = {gig_ctrl_q[anpage_pkg::GIG_MODE_HI:anpage_pkg::GIG_PORT],
                           config_strap_mode,
                           gig_ctrl_q[anpage_pkg::GIG_HDX - 1:0]};
  wire [15:0] gig_d = wr_gig ? gig_next : (strap_taken_q ? gig_ctrl_q : gig_strap);
  // Only documented modes take effect; reserved codes fall back to normal
  wire [2:0] mode_d = gig_d[anpage_pkg::GIG_MODE_HI:anpage_pkg::GIG_MODE_LO];
  wire mode_legal = mode_d <= 3'(anpage_pkg::TM_DISTORTION);

  // ----------------------------------------------------------------------
  // Latching status bits
  // ----------------------------------------------------------------------
  latch_bit #(.LATCH_HIGH(1'b1)) u_par_fault (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .live(par_fault_live),
    .rd_clr(rd_exp),
    .held_q(par_fault_q)
  );

  latch_bit #(.LATCH_HIGH(1'b0)) u_page_rx (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .live(page_rx_live),
    .rd_clr(rd_exp),
    .held_q(page_rx_q)
  );

  toggle_track u_toggle (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .page_sent(page_sent),
    .sent_toggle(sent_toggle),
    .toggle_q(toggle_q)
  );

  // ----------------------------------------------------------------------
  // Received pages
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      partner_base_q <= anpage_pkg::RST_PARTNER;
    else if (clk_en && base_page_valid)
      partner_base_q <= base_page_word & anpage_pkg::BASE_RMASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      partner_np_q <= anpage_pkg::RST_NP_RX;
    else if (clk_en && next_page_valid)
      partner_np_q <= next_page_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      partner_flags_q <= 2'h0;
    else if (clk_en)
      partner_flags_q <= {link_partner_np, link_partner_an};
  end

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      np_tx_q <= anpage_pkg::RST_NP_TX;
    else if (clk_en && wr_npt)
      np_tx_q <= npt_next;
  end

  // Decoded controls are registered alongside the word so the engine sees flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gig_ctrl_q <= anpage_pkg::RST_GIG;
      strap_taken_q <= 1'b0;
      test_mode_q <= 3'(anpage_pkg::TM_NORMAL);
      force_master_q <= 1'b0;
    end
    else if (clk_en)
    begin
      strap_taken_q <= 1'b1;
      gig_ctrl_q <= gig_d;
      test_mode_q <= mode_legal ? mode_d : 3'(anpage_pkg::TM_NORMAL);
      force_master_q <= gig_d[anpage_pkg::GIG_MANUAL] && gig_d[anpage_pkg::GIG_ROLE];
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pready_q <= setup_cyc;
      pslverr_q <= setup_cyc && !hit_any;
      prdata_q <= (setup_cyc && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------------
  // Controls
  // ----------------------------------------------------------------------
  assign np_tx_word = npt_word;
  assign test_mode = test_mode_q;
  assign manual_role_en = gig_ctrl_q[anpage_pkg::GIG_MANUAL];
  assign force_master = force_master_q;
  assign multi_port = gig_ctrl_q[anpage_pkg::GIG_PORT];
  assign adv_gig_fdx = gig_ctrl_q[anpage_pkg::GIG_FDX];
  assign adv_gig_hdx = gig_ctrl_q[anpage_pkg::GIG_HDX];

endmodule

// >>> test/anpage_props.sv
/*
  Checker for the page and gigabit control register group.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module anpage_props (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Engine side
  input wire logic par_fault_live,
  input wire logic [2:0] test_mode,
  input wire logic manual_role_en,
  input wire logic force_master,
  input wire logic multi_port
);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_fault; par_fault_live && clk_en; endsequence
  sequence s_rd_exp; psel && !penable && !pwrite && paddr == anpage_pkg::OFS_EXPANSION; endsequence
  sequence s_gig_wr;
    clk_en && pready && pwrite && pstrb[1] && paddr == anpage_pkg::OFS_GIG_CONTROL;
  endsequence
  property p_fault_hold; s_fault ##1 s_rd_exp |=> prdata[4]; endproperty
  property p_local_np; pready && !pwrite && paddr == anpage_pkg::OFS_EXPANSION |-> prdata[2];
  endproperty
  property p_exp_rsvd; pready && !pwrite && paddr == anpage_pkg::OFS_EXPANSION |-> !prdata[15:5];
  endproperty
  property p_mode_legal; test_mode <= 3'h4; endproperty
  property p_role_ignored; !manual_role_en |-> !force_master; endproperty
  property p_port_wr; s_gig_wr |=> multi_port == $past(pwdata[10]); endproperty
  property p_role_wr; s_gig_wr |=> force_master == ($past(pwdata[12]) && $past(pwdata[11]));
  endproperty
  property p_mode_wr; s_gig_wr ##0 pwdata[15:13] <= 3'h4 |=> test_mode == $past(pwdata[15:13]);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault bit not held");
  a_local_np: assert property (p_local_np) else $error("local next page bit low");
  a_exp_rsvd: assert property (p_exp_rsvd) else $error("expansion high bits set");
  a_mode_legal: assert property (p_mode_legal) else $error("reserved test mode out");
  a_role_ignored: assert property (p_role_ignored) else $error("role forced");
  a_port_wr: assert property (p_port_wr) else $error("port type not written");
  a_role_wr: assert property (p_role_wr) else $error("role not as written");
  a_mode_wr: assert property (p_mode_wr) else $error("test mode not as written");
endmodule

bind anpage_regs anpage_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .par_fault_live(par_fault_live),
  .test_mode(test_mode), .manual_role_en(manual_role_en), .force_master(force_master),
  .multi_port(multi_port));

// >>> test/anpage_regs_test.sv
/*
  Self-checking bench for the page and gigabit control register group.
  Assumes a zero-wait APB slave and one-cycle engine strobes.
*/
`timescale 1ns/1ps
module anpage_regs_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, v;
  logic [3:0] pstrb = 0;
  logic [1:0] config_strap_mode = 2'h2;
  logic base_page_valid = 0, next_page_valid = 0, par_fault_live = 0, page_rx_live = 0;
  logic link_partner_np = 0, link_partner_an = 0, page_sent = 0, sent_toggle = 0;
  logic [15:0] base_page_word = 0, next_page_word = 0, np_tx_word;
  logic [2:0] test_mode;
  logic manual_role_en, force_master, multi_port, adv_gig_fdx, adv_gig_hdx;
  logic [33:0] exp_q[$];
  logic [33:0] me;
  logic [11:0] ofs[5] = '{anpage_pkg::OFS_PARTNER_BASE, anpage_pkg::OFS_EXPANSION,
    anpage_pkg::OFS_NP_TRANSMIT, anpage_pkg::OFS_NP_RECEIVE, anpage_pkg::OFS_GIG_CONTROL};
  int miscompares = 0, total_checks = 0, cyc = 0;

  always #25 pclk = ~pclk;

  anpage_regs dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .config_strap_mode, .base_page_valid,
    .base_page_word, .next_page_valid, .next_page_word, .par_fault_live, .page_rx_live,
    .link_partner_np, .link_partner_an, .page_sent, .sent_toggle, .np_tx_word, .test_mode,
    .manual_role_en, .force_master, .multi_port, .adv_gig_fdx, .adv_gig_hdx);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_bit(input string n, input logic e, input logic g);
    chk_word(n, {31'h0, e}, {31'h0, g});
  endtask
  task end_sim;
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Entry: read flag, expected error, expected data
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0, 0, {2'b10, e});
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1, a, d, s, 34'h0);
  endtask

  // Monitor takes the oldest note per answer; the cycle ceiling cuts a hang
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      miscompares++;
      end_sim;
    end
    else if (presetn && pready === 1'b1)
    begin
      me = exp_q.pop_front();
      if (me[33])
        chk_word("prdata", me[31:0], prdata);
      chk_bit("pslverr", me[32], pslverr);
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    v = $urandom(32'hc321);
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rd(ofs[0], 32'h0);
    rd(ofs[1], 32'h4);
    rd(ofs[2], 32'h2001);
    rd(ofs[3], 32'h0);
    rd(ofs[4], 32'h0600);
    v = $urandom;
    base_page_valid <= 1;
    base_page_word <= v[15:0];
    @(posedge pclk);
    base_page_valid <= 0;
    next_page_valid <= 1;
    next_page_word <= v[31:16];
    @(posedge pclk);
    next_page_valid <= 0;
    wr(ofs[0], 32'hffff, 4'hf);
    rd(ofs[0], {16'h0, v[15:0] & 16'hefff});
    rd(ofs[3], {16'h0, v[31:16]});
    // A capture strobe while the clock enable is low must leave the word alone
    clk_en <= 0;
    base_page_valid <= 1;
    base_page_word <= ~v[15:0];
    @(posedge pclk);
    clk_en <= 1;
    base_page_valid <= 0;
    rd(ofs[0], {16'h0, v[15:0] & 16'hefff});
    link_partner_np <= 1;
    link_partner_an <= 1;
    page_rx_live <= 1;
    repeat (2) @(posedge pclk);
    par_fault_live <= 1;
    fork
      @(posedge pclk) par_fault_live <= 0;
    join_none
    rd(ofs[1], 32'h1d);
    rd(ofs[1], 32'h0f);
    page_rx_live <= 0;
    @(posedge pclk);
    page_rx_live <= 1;
    rd(ofs[1], 32'h0d);
    // Fault lands on the edge that captures the read word: shown by the next read
    fork
    begin
      @(posedge pclk) par_fault_live <= 1;
      @(posedge pclk) par_fault_live <= 0;
    end
    join_none
    rd(ofs[1], 32'h0f);
    rd(ofs[1], 32'h1f);
    wr(ofs[2], 32'hffff, 4'hf);
    rd(ofs[2], 32'hb7ff);
    wr(ofs[2], 32'h0, 4'h1);
    for (int t = 0; t < 2; t++)
    begin
      @(posedge pclk);
      page_sent <= 1;
      sent_toggle <= t[0];
      @(posedge pclk);
      page_sent <= 0;
      rd(ofs[2], {20'h0000b, !t[0], 11'h700});
      chk_word("np_tx_word", {20'h0000b, !t[0], 11'h700}, {16'h0, np_tx_word});
    end
    for (int m = 0; m < 5; m++)
    begin
      v = $urandom;
      v[31:13] = {16'h0, m[2:0]};
      wr(ofs[4], v, 4'h3);
      rd(ofs[4], v);
      chk_word("gig_out", {24'h0, v[15:12], v[12] & v[11], v[10:8]}, {24'h0, test_mode,
        manual_role_en, force_master, multi_port, adv_gig_fdx, adv_gig_hdx});
    end
    apb(0, 12'h028, 0, 0, {2'b11, 32'h0});
    apb(1, 12'h028, 32'hffff, 4'hf, {2'b01, 32'h0});
    repeat (2) @(posedge pclk);
    end_sim;
  end
endmodule
